// >>> design/cmpc_ctrl.sv
// Purpose: register control, sampling and event logic around five comparators
// Assumes: classic wishbone slave, 100 MHz clk_i, sync active-high reset
// Notes:   analog comparators sit outside; this block drives their controls
//
// Functional notes
// - over-current mode: none, rising, falling interrupt
// - mode 11 rising edge kills output enable
// - group modes: none, rising, falling, both edges
// - over-current input config: single, dual, three
// - over-current enable and hysteresis select bits
// - shared group hysteresis code drives analog
// - bus-current and group enables, one bit each
// - group mode selects group input wiring
// - group selection resets 00, picks comparators
// - motor timer rewrites group selection field
// - input switching only valid in mode 01
// - dead-time sampling enable bit
// - debug select drives the test pin
// - sampling select: phases and delayed windows
// - output select routes comparator to test pin
// - bus-current switching reroutes comparator inputs
// - scale-up multiplies sampling base period by four
// - delay is 8 or 32 times field clocks
// - event flags: write 0 clears, 1 ignored
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "cmpc_cfg.svh"

module cmpc_ctrl
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [16:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // comparator results: 0..2 group, 3 over-current, 4 bus current
    input  wire logic [4:0]  cmp_result_i,
    // pwm timing and debug sources
    input  wire logic        pwm_on_i,
    input  wire logic        dead_time_i,
    input  wire logic        zero_crossing_point_i,
    input  wire logic        adc_trigger_i,
    input  wire logic        angle_flag_i,
    // motor timer access to group selection
    input  wire logic        timer_comparator_gate_i,
    input  wire logic [1:0]  timer_group_selection_i,
    // analog controls
    output logic             overcurrent_comparator_enable_o,
    output logic [2:0]       overcurrent_input_config_o,
    output logic             overcurrent_hysteresis_select_o,
    output logic [1:0]       group_hysteresis_code_o,
    output logic             bus_current_comparator_enable_o,
    output logic             group_enable_o,
    output logic [1:0]       group_wiring_mode_o,
    output logic [2:0]       group_comparator_run_o,
    output logic             group_input_switching_o,
    output logic             bus_current_pin_switching_o,
    output logic             sampling_scale_up_enable_o,
    output logic             deadtime_sampling_enable_o,
    // results and events
    output logic [2:0]       group_sampled_o,
    output logic             sample_window_o,
    output logic [3:0]       irq_request_o,
    output logic             motor_output_enable_clear_o,
    output logic             test_pin_o
);

    // ********************
    // state
    // ********************
    cmpc_pkg::cmpc_state_t s_ff;
    cmpc_pkg::cmpc_state_t nxt_s;

    logic        acc;
    logic        wr;
    logic [14:0] idx;
    logic [7:0]  wd;
    logic [7:0]  rd;
    logic [3:0]  rise;
    logic [3:0]  fall;
    logic [3:0]  ev_set;
    logic [3:0]  ev_clr;
    logic [3:0]  irq_allow;
    logic [3:0]  cmp_now;
    logic [1:0]  oc_mode;
    logic [1:0]  gsel;
    logic [1:0]  gmode;
    logic [1:0]  sampling_phase_select;
    logic [9:0]  unit;
    logic [9:0]  on_cyc;
    logic [9:0]  tail_cyc;
    logic        edge_pwm;
    logic        cur_sel;
    logic        prev_sel;
    logic [2:0]  tsel;

    assign idx = wb_adr_i[16:2];
    assign acc = wb_cyc_i & wb_stb_i & ~s_ff.ack;
    assign wr  = acc & wb_we_i & wb_sel_i[0];
    assign wd  = wb_dat_i[7:0];

    // ********************
    // read multiplexer
    // ********************
    always_comb
    begin
        unique case (idx)
            `CMPC_IDX_IRQ_MODE:    rd = s_ff.irq_mode;
            `CMPC_IDX_OC_CFG:      rd = s_ff.oc_cfg;
            `CMPC_IDX_FLAGS:       rd = {s_ff.flags, cmp_result_i[3:0]};
            `CMPC_IDX_GROUP_CFG:   rd = s_ff.group_cfg;
            `CMPC_IDX_SAMPLE_DBG:  rd = s_ff.sample_dbg;
            `CMPC_IDX_SWITCH_CTL:  rd = s_ff.switch_ctl | {cmp_result_i[4], 7'h00};
            `CMPC_IDX_SAMPLE_TIME: rd = s_ff.sample_time;
            default:               rd = 8'h00;
        endcase
    end

    // ********************
    // next state
    // ********************
    always_comb
    begin
        nxt_s           = s_ff;
        nxt_s.ack       = acc;
        nxt_s.moe_clear = 1'b0;
        if (acc)
        begin
            nxt_s.rdata = rd;
        end
        ev_clr = 4'h0;

        // register writes; masks keep reserved bits at zero
        if (wr)
        begin
            unique case (idx)
                `CMPC_IDX_IRQ_MODE:    nxt_s.irq_mode = wd;
                `CMPC_IDX_OC_CFG:      nxt_s.oc_cfg = wd & `CMPC_MASK_OC_CFG;
                `CMPC_IDX_FLAGS:       ev_clr = ~wd[7:4];
                `CMPC_IDX_GROUP_CFG:   nxt_s.group_cfg = wd & `CMPC_MASK_GROUP_CFG;
                `CMPC_IDX_SAMPLE_DBG:  nxt_s.sample_dbg = wd;
                `CMPC_IDX_SWITCH_CTL:  nxt_s.switch_ctl = wd & `CMPC_MASK_SWITCH_CTL;
                `CMPC_IDX_SAMPLE_TIME: nxt_s.sample_time = wd;
                default:               ;
            endcase
        end

        // the timer has the last word on the selection in square-wave drive
        if (timer_comparator_gate_i)
        begin
            nxt_s.group_cfg[`CMPC_GROUP_SEL] = timer_group_selection_i;
        end

        // ------------------------------------------------------------
        // sampling window
        // ------------------------------------------------------------
        sampling_phase_select   = s_ff.sample_dbg[`CMPC_SAMPLE_SEL];
        unit     = s_ff.switch_ctl[`CMPC_SCALE_UP] ? `CMPC_DELAY_UNIT_X4
                                                    : `CMPC_DELAY_UNIT;
        on_cyc   = 10'(unit * {6'h00, s_ff.sample_time[`CMPC_ON_DELAY]});
        tail_cyc = on_cyc - 10'(unit * {6'h00, s_ff.sample_time[`CMPC_OFF_LEAD]});
        edge_pwm = pwm_on_i ^ s_ff.pwm_prev;
        cur_sel  = pwm_on_i ? sampling_phase_select[1] : sampling_phase_select[0];
        prev_sel = pwm_on_i ? sampling_phase_select[0] : sampling_phase_select[1];
        nxt_s.pwm_prev = pwm_on_i;
        if (edge_pwm)
        begin
            nxt_s.cnt = 10'h000;
        end
        else if (s_ff.cnt != `CMPC_CNT_MAX)
        begin
            nxt_s.cnt = s_ff.cnt + 10'h001;
        end
        // window opens on-delay after an edge and closes on-delay minus
        // off-lead after the following edge
        if (sampling_phase_select == 2'b00)
        begin
            nxt_s.window = 1'b1;
        end
        else
        begin
            nxt_s.window = (cur_sel && nxt_s.cnt >= on_cyc)
                         || (prev_sel && nxt_s.cnt < tail_cyc);
        end
        if (dead_time_i && !s_ff.sample_dbg[`CMPC_DT_SAMPLE_EN])
        begin
            nxt_s.window = 1'b0;
        end
        if (s_ff.window)
        begin
            nxt_s.grp_sampled = cmp_result_i[2:0];
        end

        // ------------------------------------------------------------
        // edge events: group uses sampled results, over-current raw
        // ------------------------------------------------------------
        cmp_now = {cmp_result_i[3], s_ff.grp_sampled};
        nxt_s.cmp_prev = cmp_now;
        rise = cmp_now & ~s_ff.cmp_prev;
        fall = ~cmp_now & s_ff.cmp_prev;
        oc_mode = s_ff.irq_mode[`CMPC_OC_IRQ_MODE];
        for (int i = 0; i < 3; i++)
        begin
            ev_set[i] = (rise[i] & s_ff.irq_mode[2*i])
                      | (fall[i] & s_ff.irq_mode[2*i+1]);
        end
        ev_set[3] = (rise[3] & oc_mode[0]) | (fall[3] & oc_mode == 2'b10);
        irq_allow = {oc_mode != 2'b11, 3'b111};
        if (rise[3] && oc_mode == 2'b11)
        begin
            nxt_s.moe_clear = 1'b1;
        end
        // an event in the clearing cycle survives
        nxt_s.flags = (s_ff.flags & ~ev_clr) | ev_set;
        nxt_s.irq   = nxt_s.flags & irq_allow;

        // ------------------------------------------------------------
        // analog control decode
        // ------------------------------------------------------------
        unique case (s_ff.oc_cfg[`CMPC_OC_INPUT_MODE])
            2'b00:   nxt_s.oc_input_cfg = 3'b001;
            2'b01:   nxt_s.oc_input_cfg = 3'b010;
            default: nxt_s.oc_input_cfg = 3'b100;
        endcase
        gsel  = s_ff.group_cfg[`CMPC_GROUP_SEL];
        gmode = s_ff.group_cfg[`CMPC_GROUP_MODE];
        unique case (gsel)
            2'b00:   nxt_s.grp_run = (gmode == 2'b11) ? 3'b011 : 3'b111;
            2'b01:   nxt_s.grp_run = 3'b001;
            2'b10:   nxt_s.grp_run = 3'b010;
            default: nxt_s.grp_run = (gmode == 2'b11) ? 3'b000 : 3'b100;
        endcase
        if (!s_ff.group_cfg[`CMPC_GROUP_ENABLE])
        begin
            nxt_s.grp_run = 3'b000;
        end
        nxt_s.grp_alt_inputs = s_ff.switch_ctl[`CMPC_GROUP_SWITCH]
                             && gmode == 2'b01;
        nxt_s.bus_pin_switch = s_ff.switch_ctl[`CMPC_BUS_PIN_SWITCH];
        nxt_s.filter_scale   = s_ff.switch_ctl[`CMPC_SCALE_UP];

        // ------------------------------------------------------------
        // test pin: debug select wins over comparator select
        // ------------------------------------------------------------
        tsel = s_ff.sample_dbg[`CMPC_TEST_SEL];
        unique case (s_ff.sample_dbg[`CMPC_DEBUG_SEL])
            2'b01:   nxt_s.test_pin = zero_crossing_point_i;
            2'b10:   nxt_s.test_pin = adc_trigger_i;
            2'b11:   nxt_s.test_pin = s_ff.window;
            default:
            begin
                if (tsel >= 3'b001 && tsel <= 3'b101)
                begin
                    nxt_s.test_pin = cmp_result_i[3'(tsel - 3'b001)];
                end
                else
                begin
                    nxt_s.test_pin = (tsel == 3'b111) & angle_flag_i;
                end
            end
        endcase
    end

    // ********************
    // state register
    // ********************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_ff             <= '0;
            s_ff.irq_mode    <= `CMPC_RST_IRQ_MODE;
            s_ff.oc_cfg      <= `CMPC_RST_OC_CFG;
            s_ff.group_cfg   <= `CMPC_RST_GROUP_CFG;
            s_ff.sample_dbg  <= `CMPC_RST_SAMPLE_DBG;
            s_ff.switch_ctl  <= `CMPC_RST_SWITCH_CTL;
            s_ff.sample_time <= `CMPC_RST_SAMPLE_TIME;
            s_ff.window      <= 1'b1;
            s_ff.oc_input_cfg <= 3'b001;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // ********************
    // outputs, all from the state register
    // ********************
    assign wb_dat_o = {24'h000000, s_ff.rdata};
    assign wb_ack_o = s_ff.ack;
    assign overcurrent_comparator_enable_o = s_ff.oc_cfg[`CMPC_OC_ENABLE];
    assign overcurrent_input_config_o      = s_ff.oc_input_cfg;
    assign overcurrent_hysteresis_select_o = s_ff.oc_cfg[`CMPC_OC_HYST];
    assign group_hysteresis_code_o         = s_ff.oc_cfg[`CMPC_GROUP_HYST];
    assign bus_current_comparator_enable_o = s_ff.group_cfg[`CMPC_BUS_ENABLE];
    assign group_enable_o                  = s_ff.group_cfg[`CMPC_GROUP_ENABLE];
    assign group_wiring_mode_o             = s_ff.group_cfg[`CMPC_GROUP_MODE];
    assign group_comparator_run_o          = s_ff.grp_run;
    assign group_input_switching_o         = s_ff.grp_alt_inputs;
    assign bus_current_pin_switching_o     = s_ff.bus_pin_switch;
    assign sampling_scale_up_enable_o      = s_ff.filter_scale;
    assign deadtime_sampling_enable_o      = s_ff.sample_dbg[`CMPC_DT_SAMPLE_EN];
    assign group_sampled_o                 = s_ff.grp_sampled;
    assign sample_window_o                 = s_ff.window;
    assign irq_request_o                   = s_ff.irq;
    assign motor_output_enable_clear_o     = s_ff.moe_clear;
    assign test_pin_o                      = s_ff.test_pin;

endmodule // cmpc_ctrl

// >>> design/cmpc_cfg.svh
// Purpose: constants for the comparator control block
// Assumes: wishbone byte address = 4 * register index
// Notes:   definitions only
`ifndef CMPC_CFG_SVH
`define CMPC_CFG_SVH

// ********************
// register indices (byte address is four times the index)
// ********************
`define CMPC_IDX_IRQ_MODE     15'h00d5
`define CMPC_IDX_OC_CFG       15'h00d6
`define CMPC_IDX_FLAGS        15'h00d7
`define CMPC_IDX_GROUP_CFG    15'h00da
`define CMPC_IDX_SAMPLE_DBG   15'h00dc
`define CMPC_IDX_SWITCH_CTL   15'h00e1
`define CMPC_IDX_SAMPLE_TIME  15'h40ad

// ********************
// reset values and writable-bit masks
// ********************
`define CMPC_RST_IRQ_MODE     8'h00
`define CMPC_RST_OC_CFG       8'h00
`define CMPC_RST_GROUP_CFG    8'h00
`define CMPC_RST_SAMPLE_DBG   8'h00
`define CMPC_RST_SWITCH_CTL   8'h00
`define CMPC_RST_SAMPLE_TIME  8'h01
`define CMPC_MASK_OC_CFG      8'h7b
`define CMPC_MASK_GROUP_CFG   8'hf9
`define CMPC_MASK_SWITCH_CTL  8'h16

// ********************
// field positions
// ********************
`define CMPC_OC_IRQ_MODE      7:6
`define CMPC_OC_INPUT_MODE    6:5
`define CMPC_OC_ENABLE        4
`define CMPC_OC_HYST          3
`define CMPC_GROUP_HYST       1:0
`define CMPC_BUS_ENABLE       7
`define CMPC_GROUP_MODE       6:5
`define CMPC_GROUP_SEL        4:3
`define CMPC_GROUP_ENABLE     0
`define CMPC_DT_SAMPLE_EN     7
`define CMPC_DEBUG_SEL        6:5
`define CMPC_SAMPLE_SEL       4:3
`define CMPC_TEST_SEL         2:0
`define CMPC_BUS_RESULT       7
`define CMPC_BUS_PIN_SWITCH   4
`define CMPC_SCALE_UP         2
`define CMPC_GROUP_SWITCH     1
`define CMPC_ON_DELAY         7:4
`define CMPC_OFF_LEAD         3:0

// ********************
// timing: sample delay unit in clocks, normal and scaled up
// ********************
`define CMPC_DELAY_UNIT       10'd8
`define CMPC_DELAY_UNIT_X4    10'd32
`define CMPC_CNT_MAX          10'h3ff

`endif

// >>> design/cmpc_pkg.sv
// Purpose: types of the comparator control block
// Assumes: constants live in cmpc_cfg.svh
// Notes:   the whole module state is one packed struct
package cmpc_pkg;

    typedef struct packed {
        logic       ack;
        logic [7:0] rdata;
        logic [7:0] irq_mode;
        logic [7:0] oc_cfg;
        logic [7:0] group_cfg;
        logic [7:0] sample_dbg;
        logic [7:0] switch_ctl;
        logic [7:0] sample_time;
        logic [3:0] flags;
        logic [3:0] irq;
        logic [3:0] cmp_prev;
        logic [2:0] grp_sampled;
        logic [9:0] cnt;
        logic       pwm_prev;
        logic       window;
        logic       moe_clear;
        logic       test_pin;
        logic [2:0] oc_input_cfg;
        logic [2:0] grp_run;
        logic       grp_alt_inputs;
        logic       bus_pin_switch;
        logic       filter_scale;
    } cmpc_state_t;

endpackage

// >>> testbench/cmpc_ctrl_monitor.sv
// Purpose: concurrent checks on the comparator control ports
// Assumes: shadow copies lag the design registers by one cycle
// Notes:   register-driven outputs are judged only while no ack is out
`timescale 1ns/1ps
`include "cmpc_cfg.svh"

module cmpc_ctrl_monitor
(
    // clock, reset and bus
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [16:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        wb_ack_o,
    // comparators and events
    input  wire logic [4:0]  cmp_result_i,
    input  wire logic [3:0]  irq_request_o,
    input  wire logic        motor_output_enable_clear_o,
    // analog controls
    input  wire logic        overcurrent_comparator_enable_o,
    input  wire logic [2:0]  overcurrent_input_config_o,
    input  wire logic        overcurrent_hysteresis_select_o,
    input  wire logic [1:0]  group_hysteresis_code_o,
    input  wire logic        bus_current_comparator_enable_o,
    input  wire logic        group_enable_o,
    input  wire logic [1:0]  group_wiring_mode_o,
    input  wire logic        group_input_switching_o,
    input  wire logic        bus_current_pin_switching_o,
    input  wire logic        sampling_scale_up_enable_o
);
    // ********************
    // register shadows
    // ********************
    logic [7:0]  sh_irq;
    logic [7:0]  sh_oc;
    logic [7:0]  sh_grp;
    logic [7:0]  sh_sw;
    logic [14:0] idx;
    logic        wr;
    logic        quiet;

    assign idx = wb_adr_i[16:2];
    assign wr = wb_stb_i && wb_we_i && wb_ack_o;
    // an ack marks the cycle where design and shadow may disagree
    assign quiet = !wb_ack_o;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            {sh_irq, sh_oc, sh_grp, sh_sw} <= 32'h0000_0000;
        else
        begin
            if (wr && idx == `CMPC_IDX_IRQ_MODE) sh_irq <= wb_dat_i[7:0];
            if (wr && idx == `CMPC_IDX_OC_CFG) sh_oc <= wb_dat_i[7:0];
            if (wr && idx == `CMPC_IDX_GROUP_CFG) sh_grp <= wb_dat_i[7:0];
            if (wr && idx == `CMPC_IDX_SWITCH_CTL) sh_sw <= wb_dat_i[7:0];
        end
    end

    // ********************
    // properties
    // ********************
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence oc_rise_s;
        $rose(cmp_result_i[3]);
    endsequence
    sequence oc_fall_s;
        $fell(cmp_result_i[3]);
    endsequence
    sequence pulse_s;
        motor_output_enable_clear_o ##1 !motor_output_enable_clear_o;
    endsequence

    ack_delay_a: assert property ((wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack timing wrong");
    oc_rise_a: assert property ((sh_irq[7:6] == 2'b01) ##0 oc_rise_s |=> irq_request_o[3])
        else $error("no rise irq");
    oc_fall_a: assert property ((sh_irq[7:6] == 2'b10) ##0 oc_fall_s |=> irq_request_o[3])
        else $error("no fall irq");
    oc_none_a: assert property ((sh_irq[7:6] == 2'b00) |-> !$rose(irq_request_o[3]))
        else $error("irq in mode 00");
    oc_kill_a: assert property ((sh_irq[7:6] == 2'b11) ##0 oc_rise_s |=>
        !irq_request_o[3] ##0 pulse_s)
        else $error("kill pulse wrong");
    oc_cfg_a: assert property (quiet |-> overcurrent_comparator_enable_o == sh_oc[4] &&
        overcurrent_hysteresis_select_o == sh_oc[3] && group_hysteresis_code_o == sh_oc[1:0])
        else $error("oc config wrong");
    oc_input_a: assert property (quiet |-> overcurrent_input_config_o ==
        (sh_oc[6] ? 3'b100 : (sh_oc[5] ? 3'b010 : 3'b001)))
        else $error("oc input wrong");
    grp_cfg_a: assert property (quiet |-> bus_current_comparator_enable_o == sh_grp[7] &&
        group_enable_o == sh_grp[0] && group_wiring_mode_o == sh_grp[6:5])
        else $error("group enable or wiring mode wrong");
    switch_ctl_a: assert property (quiet |-> bus_current_pin_switching_o == sh_sw[4] &&
        sampling_scale_up_enable_o == sh_sw[2] &&
        group_input_switching_o == (sh_sw[1] && sh_grp[6:5] == 2'b01))
        else $error("switching controls wrong");
endmodule // cmpc_ctrl_monitor

bind cmpc_ctrl cmpc_ctrl_monitor i_monitor
(
    .clk_i, .rst_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .cmp_result_i,
    .irq_request_o, .motor_output_enable_clear_o, .overcurrent_comparator_enable_o,
    .overcurrent_input_config_o, .overcurrent_hysteresis_select_o, .group_hysteresis_code_o,
    .bus_current_comparator_enable_o, .group_enable_o, .group_wiring_mode_o,
    .group_input_switching_o, .bus_current_pin_switching_o, .sampling_scale_up_enable_o
);

// >>> testbench/cmpc_ctrl_test.sv
// Purpose: self-checking bench for the comparator control block
// Assumes: one 8-bit register per aligned word, low byte
// Notes:   read data is checked against a queue of expected bytes
`timescale 1ns/1ps
`include "cmpc_cfg.svh"

module cmpc_ctrl_test;
    // ********************
    // signals and design
    // ********************
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [16:0] wb_adr_i = 17'h0_0000;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [4:0]  cmp_result_i = 5'h00;
    logic        pwm_on_i = 1'b0;
    logic        dead_time_i = 1'b0;
    logic        zero_crossing_point_i = 1'b0;
    logic        adc_trigger_i = 1'b0;
    logic        angle_flag_i = 1'b0;
    logic        timer_comparator_gate_i = 1'b0;
    logic [1:0]  timer_group_selection_i = 2'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [2:0]  group_comparator_run_o;
    logic [2:0]  group_sampled_o;
    logic        deadtime_sampling_enable_o;
    logic        sample_window_o;
    logic [3:0]  irq_request_o;
    logic        test_pin_o;
    logic [7:0]  exp_q [$];
    int          n_fail = 0;
    int          total_checks = 0;
    logic [14:0] ix [6] = '{`CMPC_IDX_IRQ_MODE, `CMPC_IDX_OC_CFG, `CMPC_IDX_GROUP_CFG,
                           `CMPC_IDX_SAMPLE_DBG, `CMPC_IDX_SWITCH_CTL, `CMPC_IDX_SAMPLE_TIME};
    logic [7:0]  msk [6] = '{8'hff, 8'h7b, 8'hf9, 8'hff, 8'h16, 8'hff};
    logic [7:0]  rst_v [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    logic [7:0]  pin_sel [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h20, 8'h40};
    int          pin_src [8] = '{0, 1, 2, 3, 4, 7, 5, 6};
    localparam logic [14:0] fl = `CMPC_IDX_FLAGS;
    localparam logic [14:0] dbg = `CMPC_IDX_SAMPLE_DBG;

    always #5 clk_i = ~clk_i;

    cmpc_ctrl i_dut
    (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .cmp_result_i, .pwm_on_i, .dead_time_i, .zero_crossing_point_i,
        .adc_trigger_i, .angle_flag_i, .timer_comparator_gate_i, .timer_group_selection_i,
        .overcurrent_comparator_enable_o(), .overcurrent_input_config_o(),
        .overcurrent_hysteresis_select_o(), .group_hysteresis_code_o(),
        .bus_current_comparator_enable_o(), .group_enable_o(), .group_wiring_mode_o(),
        .group_comparator_run_o, .group_input_switching_o(), .bus_current_pin_switching_o(),
        .sampling_scale_up_enable_o(), .deadtime_sampling_enable_o, .group_sampled_o,
        .sample_window_o, .irq_request_o, .motor_output_enable_clear_o(), .test_pin_o
    );

    // ********************
    // tasks
    // ********************
    task automatic end_of_test();
        if (n_fail == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t %s got %b", $time, what, got);
        end
    endtask

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t read %h expected %h", $time, got, exp);
        end
    endtask

    // classic cycle; the request stands until ack is sampled high
    task automatic wb(input logic we, input logic [14:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h00_0000, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 16)
        begin
            @(posedge clk_i);
            n++;
        end
        chk_bit(wb_ack_o, 1'b1, "ack");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [14:0] idx, input logic [7:0] e);
        exp_q.push_back(e);
        wb(1'b0, idx, 8'h00);
    endtask

    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            chk_rd(wb_dat_o, exp_q.size() > 0 ? {24'h0, exp_q.pop_front()} : 32'hx);
    end

    initial
    begin
        #500_000;
        n_fail++;
        end_of_test();
    end

    // ********************
    // scenarios
    // ********************
    initial
    begin
        logic [7:0] d;
        int u;
        void'($urandom(32'h1284));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (ix[i]) rd(ix[i], rst_v[i]);
        rd(fl, 8'h00);
        wb(1'b1, 15'h0001, 8'hff);
        rd(15'h0001, 8'h00);
        repeat (8)
            foreach (ix[i])
            begin
                d = 8'($urandom);
                wb(1'b1, ix[i], d);
                rd(ix[i], d & msk[i]);
            end
        wb(1'b1, `CMPC_IDX_SWITCH_CTL, 8'h00);
        wb(1'b1, `CMPC_IDX_OC_CFG, 8'h10);
        wb(1'b1, `CMPC_IDX_GROUP_CFG, 8'h01);
        wb(1'b1, dbg, 8'h00);
        for (int c = 0; c < 4; c++)
            for (int m = 0; m < 4; m++)
            begin
                wb(1'b1, `CMPC_IDX_IRQ_MODE, 8'(m << (2 * c)));
                repeat (3) @(posedge clk_i);
                cmp_result_i[c] <= 1'b1;
                repeat (5) @(posedge clk_i);
                chk_bit(irq_request_o[c], m == 1 || (m == 3 && c < 3), "rise");
                chk_bit(group_sampled_o[c % 3], c < 3, "sampled");
                cmp_result_i[c] <= 1'b0;
                repeat (5) @(posedge clk_i);
                chk_bit(irq_request_o[c], m != 0 && !(m == 3 && c == 3), "fall");
                d = (m != 0) ? (8'h10 << c) : 8'h00;
                rd(fl, d);
                wb(1'b1, fl, 8'hf0);
                rd(fl, d);
                wb(1'b1, fl, 8'h00);
                rd(fl, 8'h00);
            end
        foreach (pin_sel[i])
        begin
            wb(1'b1, dbg, pin_sel[i]);
            {angle_flag_i, adc_trigger_i, zero_crossing_point_i, cmp_result_i} <= 8'h01 << pin_src[i];
            repeat (3) @(posedge clk_i);
            chk_bit(test_pin_o, 1'b1, "pin high");
            {angle_flag_i, adc_trigger_i, zero_crossing_point_i, cmp_result_i} <= ~(8'h01 << pin_src[i]);
            repeat (3) @(posedge clk_i);
            chk_bit(test_pin_o, 1'b0, "pin low");
        end
        wb(1'b1, dbg, 8'h00);
        repeat (3) @(posedge clk_i);
        chk_bit(test_pin_o, 1'b0, "pin off");
        wb(1'b1, dbg, 8'h60);
        repeat (3) @(posedge clk_i);
        chk_bit(test_pin_o, 1'b1, "pin window");
        wb(1'b1, `CMPC_IDX_SAMPLE_TIME, 8'h21);
        for (int s = 0; s < 2; s++)
        begin
            u = s ? 32 : 8;
            wb(1'b1, `CMPC_IDX_SWITCH_CTL, s ? 8'h04 : 8'h00);
            wb(1'b1, dbg, s ? 8'h78 : 8'h70);
            repeat (200) @(posedge clk_i);
            pwm_on_i <= 1'b1;
            repeat (2 * u - 4) @(posedge clk_i);
            chk_bit(sample_window_o, 1'b0, "early");
            repeat (8) @(posedge clk_i);
            chk_bit(sample_window_o, 1'b1, "open");
            pwm_on_i <= 1'b0;
            repeat (u / 2) @(posedge clk_i);
            chk_bit(sample_window_o, 1'b1, "lead");
            repeat (u) @(posedge clk_i);
            chk_bit(sample_window_o, 1'b0, "closed");
        end
        wb(1'b1, dbg, 8'h00);
        dead_time_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk_bit(sample_window_o, 1'b0, "dead off");
        wb(1'b1, dbg, 8'h80);
        repeat (3) @(posedge clk_i);
        chk_bit(sample_window_o, 1'b1, "dead on");
        chk_bit(deadtime_sampling_enable_o, 1'b1, "dead en");
        dead_time_i <= 1'b0;
        timer_group_selection_i <= 2'b10;
        timer_comparator_gate_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk_bit(group_comparator_run_o === 3'b010, 1'b1, "timer run");
        timer_comparator_gate_i <= 1'b0;
        @(posedge clk_i);
        rd(`CMPC_IDX_GROUP_CFG, 8'h11);
        end_of_test();
    end
endmodule // cmpc_ctrl_test
